// File: src/tbt_pkg.sv
// package: register map, field positions, timing constants and carriers of the 10base-t supervisor
package tbt_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_OPS   = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_MODE  = 8'h08;
	localparam logic [7:0] OFF_IRQS  = 8'h0C;
	localparam logic [7:0] OFF_IRQM  = 8'h10;
	// operations register fields
	localparam int OPS_SQE_INH  = 2;
	localparam int OPS_POL_INH  = 3;
	localparam int OPS_JAB_INH  = 5;
	localparam int OPS_POL_REV  = 14;
	// detailed status fields
	localparam int STAT_LINK    = 0;
	localparam int STAT_JAB     = 2;
	// mode register fields
	localparam int MODE_FDX     = 0;
	localparam int MODE_RPT     = 1;
	localparam int MODE_100     = 2;
	localparam int MODE_MDIX_LO = 8;
	// interrupt bits
	localparam int IRQ_JAB      = 0;
	localparam int IRQ_POL      = 1;
	localparam int IRQ_LFAIL    = 2;
	localparam int IRQ_SQE      = 3;
	localparam int IRQ_W        = 4;
	// reset values
	localparam logic [15:0] OPS_RST   = 16'h0000;
	localparam logic [15:0] MODE_RST  = 16'h0300;
	localparam logic [3:0]  IRQM_RST  = 4'h0;
	// timing
	localparam int CLK_NS       = 10;
	localparam int BIT_NS       = 100;
	localparam int BIT_CYC      = (BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam int JAB_MS       = 20;
	localparam int UNJAB_MS     = 500;
	localparam int LFAIL_MS     = 82;
	localparam int BT_PER_MS    = 1000000 / BIT_NS;
	localparam int JAB_BT       = JAB_MS * BT_PER_MS;
	localparam int UNJAB_BT     = UNJAB_MS * BT_PER_MS;
	localparam int LFAIL_BT     = LFAIL_MS * BT_PER_MS;
	localparam int SQE_DLY_BT   = 10;
	localparam int SQE_LEN_BT   = 10;
	localparam int NLP_VALID    = 7;
	localparam int CNT_W        = 24;

	typedef enum logic [1:0] {
		J_IDLE = 2'b00,
		J_TX   = 2'b01,
		J_JAB  = 2'b11,
		J_END  = 2'b10
	} tbt_jab_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_DLY  = 2'b01,
		S_COL  = 2'b11
	} tbt_sqe_t;

	// mac-side inputs
	typedef struct packed {
		logic tx_en;
		logic tx_data;
		logic rx_active;
		logic rx_data;
	} tbt_mac_t;

	// line receiver indications: nlp_seen is a one-cycle pulse, nlp_reversed is read with it, an_active is a level
	typedef struct packed {
		logic nlp_seen;
		logic nlp_reversed;
		logic an_active;
	} tbt_line_t;
endpackage : tbt_pkg

// File: src/tbt_super.sv
// 10base-t collision, jabber, sqe test and auto-polarity supervisor with apb registers
module tbt_super #(
	parameter int JAB_BT   = tbt_pkg::JAB_BT,
	parameter int UNJAB_BT = tbt_pkg::UNJAB_BT,
	parameter int LFAIL_BT = tbt_pkg::LFAIL_BT
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// mac and line side
	input  wire tbt_pkg::tbt_mac_t mac,
	input  wire tbt_pkg::tbt_line_t line_in,
	output logic                   col,
	output logic                   line_tx_data,
	output logic                   line_tx_nlp,
	output logic                   rx_data_out,
	output logic [1:0]             mdix_mode,
	output logic                   irq
);
	// bit-time enable
	logic [3:0] div_q, div_d;
	logic       bit_q, bit_d;

	always_comb begin
		div_d = div_q + 4'd1;
		bit_d = 1'b0;
		if (div_q == 4'(tbt_pkg::BIT_CYC - 1)) begin
			div_d = 4'd0;
			bit_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div_q <= 4'd0;
			bit_q <= 1'b0;
		end else begin
			div_q <= div_d;
			bit_q <= bit_d;
		end
	end

	// apb access decode
	logic setup_acc, done_acc, wr_en, rd_done;
	assign setup_acc = psel & penable & ~pready;
	assign done_acc  = psel & penable & pready;
	assign wr_en     = done_acc & pwrite;
	assign rd_done   = done_acc & ~pwrite;

	// control registers
	logic [15:0] ops_q, ops_d, mode_q, mode_d;
	logic [3:0]  irqm_q, irqm_d;
	logic        fdx, rpt, m100;
	assign fdx  = mode_q[tbt_pkg::MODE_FDX];
	assign rpt  = mode_q[tbt_pkg::MODE_RPT];
	assign m100 = mode_q[tbt_pkg::MODE_100];

	always_comb begin
		ops_d  = ops_q;
		mode_d = mode_q;
		irqm_d = irqm_q;
		if (wr_en && paddr == tbt_pkg::OFF_OPS) begin
			ops_d = pwdata[15:0] & 16'h002C;
		end else if (wr_en && paddr == tbt_pkg::OFF_MODE) begin
			mode_d = pwdata[15:0] & 16'h0307;
		end else if (wr_en && paddr == tbt_pkg::OFF_IRQM) begin
			irqm_d = pwdata[3:0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ops_q  <= tbt_pkg::OPS_RST;
			mode_q <= tbt_pkg::MODE_RST;
			irqm_q <= tbt_pkg::IRQM_RST;
		end else begin
			ops_q  <= ops_d;
			mode_q <= mode_d;
			irqm_q <= irqm_d;
		end
	end

	// link monitor
	logic [tbt_pkg::CNT_W-1:0] lidle_q, lidle_d;
	logic [2:0]                nlpc_q, nlpc_d;
	logic                      link_q, link_d, lfail_ev;

	always_comb begin
		lidle_d  = lidle_q;
		nlpc_d   = nlpc_q;
		link_d   = link_q;
		lfail_ev = 1'b0;
		if (line_in.nlp_seen || mac.rx_active) begin
			lidle_d = '0;
			if (mac.rx_active) begin
				link_d = 1'b1;
			end else if (nlpc_q == 3'(tbt_pkg::NLP_VALID)) begin
				link_d = 1'b1;
			end else begin
				nlpc_d = nlpc_q + 3'd1;
			end
		end else if (bit_q) begin
			if (lidle_q >= tbt_pkg::CNT_W'(LFAIL_BT)) begin
				lfail_ev = link_q;
				link_d   = 1'b0;
				nlpc_d   = 3'd0;
			end else begin
				lidle_d = lidle_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lidle_q <= '0;
			nlpc_q  <= 3'd0;
			link_q  <= 1'b0;
		end else begin
			lidle_q <= lidle_d;
			nlpc_q  <= nlpc_d;
			link_q  <= link_d;
		end
	end

	// jabber timer
	tbt_pkg::tbt_jab_t         jst_q, jst_d;
	logic [tbt_pkg::CNT_W-1:0] jcnt_q, jcnt_d;
	logic                      jab_ev, jab_blk;
	assign jab_blk = (jst_q == tbt_pkg::J_JAB) || (jst_q == tbt_pkg::J_END);

	always_comb begin
		jst_d  = jst_q;
		jcnt_d = jcnt_q;
		jab_ev = 1'b0;
		case (jst_q)
			tbt_pkg::J_IDLE: begin
				jcnt_d = '0;
				if (mac.tx_en && !ops_q[tbt_pkg::OPS_JAB_INH]) begin
					jst_d = tbt_pkg::J_TX;
				end
			end
			tbt_pkg::J_TX: begin
				if (!mac.tx_en || ops_q[tbt_pkg::OPS_JAB_INH]) begin
					jst_d = tbt_pkg::J_IDLE;
				end else if (bit_q) begin
					if (jcnt_q >= tbt_pkg::CNT_W'(JAB_BT)) begin
						jst_d  = tbt_pkg::J_JAB;
						jcnt_d = '0;
						jab_ev = 1'b1;
					end else begin
						jcnt_d = jcnt_q + 1'b1;
					end
				end
			end
			tbt_pkg::J_JAB: begin
				if (bit_q) begin
					if (jcnt_q >= tbt_pkg::CNT_W'(UNJAB_BT)) begin
						jst_d = tbt_pkg::J_END;
					end else begin
						jcnt_d = jcnt_q + 1'b1;
					end
				end
			end
			default: begin
				// stay cut off until the mac lets go, so a stuck tx_en never resumes
				if (!mac.tx_en) begin
					jst_d = tbt_pkg::J_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			jst_q  <= tbt_pkg::J_IDLE;
			jcnt_q <= '0;
		end else begin
			jst_q  <= jst_d;
			jcnt_q <= jcnt_d;
		end
	end

	// sqe test
	tbt_pkg::tbt_sqe_t sst_q, sst_d;
	logic [4:0]        scnt_q, scnt_d;
	logic              txen_q, sqe_ok, sqe_ev;
	assign sqe_ok = !rpt && !fdx && link_q && !ops_q[tbt_pkg::OPS_SQE_INH];

	always_comb begin
		sst_d  = sst_q;
		scnt_d = scnt_q;
		sqe_ev = 1'b0;
		case (sst_q)
			tbt_pkg::S_IDLE: begin
				scnt_d = 5'd0;
				if (txen_q && !mac.tx_en && sqe_ok && !jab_blk) begin
					sst_d = tbt_pkg::S_DLY;
				end
			end
			tbt_pkg::S_DLY: begin
				if (!sqe_ok) begin
					sst_d = tbt_pkg::S_IDLE;
				end else if (bit_q) begin
					if (scnt_q == 5'(tbt_pkg::SQE_DLY_BT - 1)) begin
						sst_d  = tbt_pkg::S_COL;
						scnt_d = 5'd0;
					end else begin
						scnt_d = scnt_q + 5'd1;
					end
				end
			end
			default: begin
				if (bit_q) begin
					if (scnt_q == 5'(tbt_pkg::SQE_LEN_BT - 1)) begin
						sst_d  = tbt_pkg::S_IDLE;
						sqe_ev = 1'b1;
					end else begin
						scnt_d = scnt_q + 5'd1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sst_q  <= tbt_pkg::S_IDLE;
			scnt_q <= 5'd0;
			txen_q <= 1'b0;
		end else begin
			sst_q  <= sst_d;
			scnt_q <= scnt_d;
			txen_q <= mac.tx_en;
		end
	end

	// polarity detection
	logic pol_q, pol_d, pol_win, pol_ev;
	assign pol_win = m100 ? line_in.an_active : !mac.rx_active;

	always_comb begin
		pol_d  = pol_q;
		pol_ev = 1'b0;
		if (ops_q[tbt_pkg::OPS_POL_INH]) begin
			pol_d = 1'b0;
		end else if (line_in.nlp_seen && pol_win) begin
			pol_d  = line_in.nlp_reversed;
			pol_ev = line_in.nlp_reversed & ~pol_q;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pol_q <= 1'b0;
		end else begin
			pol_q <= pol_d;
		end
	end

	// latching flags, sticky interrupts
	logic       jflag_q, jflag_d, pflag_q, pflag_d;
	logic [3:0] irqs_q, irqs_d, ev;
	assign ev = {sqe_ev, lfail_ev, pol_ev, jab_ev};

	always_comb begin
		jflag_d = jflag_q;
		pflag_d = pflag_q;
		irqs_d  = irqs_q;
		if (rd_done && paddr == tbt_pkg::OFF_STAT) begin
			jflag_d = jab_blk;
		end
		if (rd_done && paddr == tbt_pkg::OFF_OPS) begin
			pflag_d = pol_q;
		end
		if (wr_en && paddr == tbt_pkg::OFF_IRQS) begin
			irqs_d = irqs_q & ~pwdata[3:0];
		end
		// a set in the clearing cycle wins
		if (jab_ev) begin
			jflag_d = 1'b1;
		end
		if (pol_ev) begin
			pflag_d = 1'b1;
		end
		irqs_d = irqs_d | ev;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			jflag_q <= 1'b0;
			pflag_q <= 1'b0;
			irqs_q  <= 4'h0;
		end else begin
			jflag_q <= jflag_d;
			pflag_q <= pflag_d;
			irqs_q  <= irqs_d;
		end
	end

	// mac and line outputs
	logic col_d, txd_d, nlp_d, rxd_d;

	always_comb begin
		col_d = 1'b0;
		if (!fdx) begin
			col_d = mac.rx_active & mac.tx_en;
			if (jab_blk) begin
				col_d = 1'b1;
			end
			if (sst_q == tbt_pkg::S_COL) begin
				col_d = 1'b1;
			end
		end
		if (jab_blk && !fdx) begin
			col_d = 1'b1;
		end else if (fdx) begin
			col_d = 1'b0;
		end
		txd_d = mac.tx_data & mac.tx_en & ~jab_blk;
		nlp_d = ~mac.tx_en | jab_blk;
		rxd_d = mac.rx_data ^ pol_q;
	end

	// apb answer
	logic [31:0] rdat_d;
	logic        err_d;

	always_comb begin
		rdat_d = 32'h0000_0000;
		err_d  = 1'b0;
		if (paddr == tbt_pkg::OFF_OPS) begin
			rdat_d[15:0]                 = ops_q;
			rdat_d[tbt_pkg::OPS_POL_REV] = pflag_q;
		end else if (paddr == tbt_pkg::OFF_STAT) begin
			rdat_d[tbt_pkg::STAT_LINK] = link_q;
			rdat_d[tbt_pkg::STAT_JAB]  = jflag_q;
		end else if (paddr == tbt_pkg::OFF_MODE) begin
			rdat_d[15:0] = mode_q;
		end else if (paddr == tbt_pkg::OFF_IRQS) begin
			rdat_d[3:0] = irqs_q;
		end else if (paddr == tbt_pkg::OFF_IRQM) begin
			rdat_d[3:0] = irqm_q;
		end else begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			col          <= 1'b0;
			line_tx_data <= 1'b0;
			line_tx_nlp  <= 1'b1;
			rx_data_out  <= 1'b0;
			mdix_mode    <= 2'b11;
			irq          <= 1'b0;
			prdata       <= 32'h0000_0000;
			pready       <= 1'b0;
			pslverr      <= 1'b0;
		end else begin
			col          <= col_d;
			line_tx_data <= txd_d;
			line_tx_nlp  <= nlp_d;
			rx_data_out  <= rxd_d;
			mdix_mode    <= mode_q[tbt_pkg::MODE_MDIX_LO +: 2];
			irq          <= |(irqs_q & irqm_q);
			pready       <= setup_acc;
			pslverr      <= setup_acc & err_d;
			if (setup_acc) begin
				prdata <= pwrite ? 32'h0000_0000 : rdat_d;
			end
		end
	end
endmodule : tbt_super

// File: dv/tbt_mac_model.sv
// mac partner model: transmit and receive activity toward the supervisor
module tbt_mac_model (
	// clock
	input  wire logic         mclk,
	// mac side
	output tbt_pkg::tbt_mac_t mac
);
	timeunit 1ns;
	timeprecision 1ps;
	logic txe;
	logic rxa;
	logic tog;
	initial begin
		txe <= 1'b0;
		rxa <= 1'b0;
		tog <= 1'b0;
	end
	// data toggles every cycle so an ungated or stuck path cannot hide
	always @(posedge mclk) tog <= ~tog;
	assign mac = '{txe, txe & tog, rxa, tog};
	task automatic tx(input logic v);
		@(posedge mclk);
		txe <= v;
	endtask : tx
	task automatic rx(input logic v);
		@(posedge mclk);
		rxa <= v;
	endtask : rx
endmodule : tbt_mac_model

// File: dv/tbt_super_monitor.sv
// port checker of the 10base-t supervisor
module tbt_super_monitor #(
	parameter int JAB_BT = 20
) (
	// clock and reset
	input wire logic              mclk,
	input wire logic              rst,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// mac and line
	input wire tbt_pkg::tbt_mac_t mac,
	input wire logic              col,
	input wire logic              line_tx_nlp,
	input wire logic [1:0]        mdix_mode
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// margin covers the bit-tick alignment of the jabber timer
	localparam int JC = JAB_BT * 10 + 20;
	logic        wr;
	logic        fdx_q;
	logic        jinh_q;
	logic [1:0]  md_q;
	logic [15:0] txc_q;
	assign wr = psel && penable && pready && pwrite;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			fdx_q <= 1'b0;
			jinh_q <= 1'b0;
			md_q <= 2'b11;
			txc_q <= '0;
		end else begin
			txc_q <= mac.tx_en ? txc_q + 16'h0001 : '0;
			if (wr && paddr == tbt_pkg::OFF_MODE) begin
				fdx_q <= pwdata[0];
				md_q <= pwdata[9:8];
			end
			if (wr && paddr == tbt_pkg::OFF_OPS) jinh_q <= pwdata[5];
		end
	end
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	sequence mode_wr_s;
		wr && paddr == tbt_pkg::OFF_MODE;
	endsequence
	apb_wait_a: assert property (acc_s |=> pready) else $error("no answer after one wait");
	apb_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	err_addr_a: assert property (pslverr |-> pready && paddr > 8'h10) else $error("bad pslverr");
	err_data_a: assert property (pslverr && !pwrite |-> prdata == '0) else $error("bad err data");
	col_hdx_a:
		assert property (mac.rx_active && mac.tx_en && !fdx_q |=> col) else $error("no col");
	col_fdx_a:
		assert property (fdx_q && $past(fdx_q) |-> !col) else $error("col in full duplex");
	jab_cut_a:
		assert property (txc_q > JC && !jinh_q && !fdx_q |-> col && line_tx_nlp)
		else $error("jabber not cut");
	jab_off_a:
		assert property (txc_q > 2 && jinh_q |-> !line_tx_nlp) else $error("jabber inhibited");
	mdix_copy_a:
		assert property (mode_wr_s |-> ##2 mdix_mode == md_q) else $error("mdix not copied");
endmodule : tbt_super_monitor
bind tbt_super tbt_super_monitor #(.JAB_BT(JAB_BT)) u_mon (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .mac(mac), .col(col), .line_tx_nlp(line_tx_nlp),
	.mdix_mode(mdix_mode)
);

// File: dv/test_tbt_super.sv
// self-checking bench of the 10base-t supervisor
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_tbt_super;
	timeunit 1ns;
	timeprecision 1ps;
	logic               mclk;
	logic               rst;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata, rdat;
	logic               pready, pslverr, perr;
	logic               col, line_tx_data, line_tx_nlp, rx_data_out, irq;
	logic [1:0]         mdix_mode;
	tbt_pkg::tbt_mac_t  mac;
	tbt_pkg::tbt_line_t line_in;
	int                 error_cnt = 0;
	int                 checked = 0;
	int                 cyc = 0;
	tbt_mac_model mm (.mclk(mclk), .mac(mac));
	tbt_super #(.JAB_BT(20), .UNJAB_BT(30), .LFAIL_BT(50)) dut (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mac(mac), .line_in(line_in), .col(col),
		.line_tx_data(line_tx_data), .line_tx_nlp(line_tx_nlp),
		.rx_data_out(rx_data_out), .mdix_mode(mdix_mode), .irq(irq)
	);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdat = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic nlp(input logic r, input int k);
		repeat (k) begin
			@(posedge mclk);
			line_in <= '{1'b1, r, line_in.an_active};
			@(posedge mclk);
			line_in.nlp_seen <= 1'b0;
		end
	endtask : nlp
	task automatic rxchk(input logic inv);
		logic v;
		@(posedge mclk);
		v = mac.rx_data;
		#1;
		`CHK(rx_data_out, v ^ inv)
	endtask : rxchk
	// unblocked transmit data must reach the line one cycle later
	task automatic txchk;
		logic v;
		repeat (2) begin
			@(posedge mclk);
			v = mac.tx_data;
			#1;
			`CHK(line_tx_data, v)
		end
	endtask : txchk
	task automatic sqe(input logic e, input logic lk);
		int n;
		n = 0;
		if (lk) nlp(1'b0, 8);
		mm.tx(1'b1);
		repeat (30) @(posedge mclk);
		mm.tx(1'b0);
		repeat (260) begin
			@(posedge mclk);
			n += col;
		end
		`CHK(n > 85 && n < 115, e)
		`CHK(n == 0, !e)
	endtask : sqe
	task automatic t_reset;
		`CHK(mdix_mode, 2'b11)
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat, 32'h0000_0000)
		apb(1'b0, tbt_pkg::OFF_MODE, '0);
		`CHK(rdat, 32'h0000_0300)
		apb(1'b0, tbt_pkg::OFF_IRQM, '0);
		`CHK(rdat, 32'h0000_0000)
		apb(1'b0, 8'h40, '0);
		`CHK({perr, rdat}, {1'b1, 32'h0000_0000})
		apb(1'b1, tbt_pkg::OFF_MODE, '0);
		repeat (3) @(posedge mclk);
		`CHK(mdix_mode, 2'b00)
	endtask : t_reset
	task automatic t_col;
		mm.rx(1'b1);
		mm.tx(1'b1);
		repeat (3) @(posedge mclk);
		`CHK(col, 1'b1)
		apb(1'b1, tbt_pkg::OFF_MODE, 32'h0000_0001);
		repeat (3) @(posedge mclk);
		`CHK(col, 1'b0)
		mm.tx(1'b0);
		mm.rx(1'b0);
		apb(1'b1, tbt_pkg::OFF_MODE, '0);
	endtask : t_col
	task automatic t_sqe;
		logic [7:0]  a [3];
		logic [31:0] v [3];
		a = '{tbt_pkg::OFF_OPS, tbt_pkg::OFF_MODE, tbt_pkg::OFF_MODE};
		v = '{32'h0000_0004, 32'h0000_0002, 32'h0000_0001};
		sqe(1'b1, 1'b1);
		apb(1'b0, tbt_pkg::OFF_STAT, '0);
		`CHK(rdat[tbt_pkg::STAT_LINK], 1'b1)
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, a[i], v[i]);
			sqe(1'b0, 1'b1);
			apb(1'b1, a[i], '0);
		end
		repeat (600) @(posedge mclk);
		apb(1'b0, tbt_pkg::OFF_STAT, '0);
		`CHK(rdat[tbt_pkg::STAT_LINK], 1'b0)
		sqe(1'b0, 1'b0);
		`CHK(irq, 1'b0)
		apb(1'b1, tbt_pkg::OFF_IRQM, 32'h0000_0004);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b1)
		apb(1'b1, tbt_pkg::OFF_IRQS, 32'h0000_0004);
		repeat (2) @(posedge mclk);
		`CHK(irq, 1'b0)
	endtask : t_sqe
	task automatic t_jab;
		mm.tx(1'b1);
		repeat (260) @(posedge mclk);
		`CHK({col, line_tx_nlp}, 2'b11)
		repeat (2) begin
			@(posedge mclk);
			`CHK(line_tx_data, 1'b0)
		end
		apb(1'b0, tbt_pkg::OFF_STAT, '0);
		`CHK(rdat[tbt_pkg::STAT_JAB], 1'b1)
		apb(1'b0, tbt_pkg::OFF_IRQS, '0);
		`CHK(rdat[3:0], 4'h9)
		mm.tx(1'b0);
		repeat (400) @(posedge mclk);
		apb(1'b0, tbt_pkg::OFF_STAT, '0);
		`CHK(rdat[tbt_pkg::STAT_JAB], 1'b1)
		apb(1'b0, tbt_pkg::OFF_STAT, '0);
		`CHK(rdat[tbt_pkg::STAT_JAB], 1'b0)
		apb(1'b1, tbt_pkg::OFF_OPS, 32'h0000_0020);
		mm.tx(1'b1);
		repeat (260) @(posedge mclk);
		`CHK(line_tx_nlp, 1'b0)
		txchk;
		mm.tx(1'b0);
		apb(1'b1, tbt_pkg::OFF_OPS, '0);
	endtask : t_jab
	task automatic t_pol;
		nlp(1'b1, 1);
		rxchk(1'b1);
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b1)
		nlp(1'b0, 1);
		rxchk(1'b0);
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b1)
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b0)
		apb(1'b1, tbt_pkg::OFF_OPS, 32'h0000_0008);
		nlp(1'b1, 1);
		rxchk(1'b0);
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b0)
		apb(1'b1, tbt_pkg::OFF_OPS, '0);
		// a pulse seen while receiving is outside the 10base-t window
		mm.rx(1'b1);
		nlp(1'b1, 1);
		mm.rx(1'b0);
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b0)
		apb(1'b1, tbt_pkg::OFF_MODE, 32'h0000_0004);
		line_in.an_active <= 1'b1;
		nlp(1'b1, 1);
		apb(1'b0, tbt_pkg::OFF_OPS, '0);
		`CHK(rdat[tbt_pkg::OPS_POL_REV], 1'b1)
		line_in.an_active <= 1'b0;
	endtask : t_pol
	// hang guard, well above the few thousand cycles the tasks need
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			error_cnt++;
			tally_and_finish;
		end
	end
	initial begin
		rst <= 1'b1;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= '0;
		pwdata <= '0;
		line_in <= '0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		t_reset;
		t_col;
		t_sqe;
		t_jab;
		t_pol;
		tally_and_finish;
	end
endmodule : test_tbt_super
